// >>> hdl/asq_pkg.sv
// Shared constants and types of the sample sequencer.
package asq_pkg;
  // ---------------------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------------------
  localparam int          NSEQ      = 4;
  localparam int          RES_W     = 10;
  localparam int          MAX_SMP   = 8;
  localparam int          CLK_MHZ   = 125;
  localparam int          SAMPLE_NS = 2000;  // One sample period at 500 ksps.
  localparam int          PACE_CYC  = SAMPLE_NS * CLK_MHZ / 1000;
  localparam logic [7:0]  PACE_MAX  = 8'(PACE_CYC - 1);
  localparam logic [2:0]  AVG_MAX   = 3'h6;  // Two to the sixth is 64 conversions.
  // Depth and sample limit per sequence, sequence 0 in the low nibble.
  localparam logic [15:0] SEQ_DEPTH = 16'h1448;
  // ---------------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  A_ENABLE  = 8'h00;
  localparam logic [7:0]  A_RAWSTAT = 8'h04;
  localparam logic [7:0]  A_MASK    = 8'h08;
  localparam logic [7:0]  A_STATCLR = 8'h0C;
  localparam logic [7:0]  A_TRIGSEL = 8'h10;
  localparam logic [7:0]  A_SWTRIG  = 8'h14;
  localparam logic [7:0]  A_PRIO    = 8'h18;
  localparam logic [7:0]  A_AVG     = 8'h1C;
  localparam logic [7:0]  A_OVFL    = 8'h20;
  localparam logic [7:0]  A_UNFL    = 8'h24;
  localparam logic [1:0]  A_SEQ_SEL = 2'h1;  // Address bits 7:6 of a sequence window.
  localparam logic [1:0]  S_MUX     = 2'h0;  // Word within window, bits 3:2.
  localparam logic [1:0]  S_CTL     = 2'h1;
  localparam logic [1:0]  S_FIFO    = 2'h2;
  localparam logic [1:0]  S_FSTAT   = 2'h3;
  localparam logic [7:0]  PRIO_RST  = 8'hE4;  // Sequence 0 highest, 3 lowest.
  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int          CTL_DIFF  = 0;
  localparam int          CTL_END   = 1;
  localparam int          CTL_IE    = 2;
  localparam int          FST_EMPTY = 8;
  localparam int          FST_FULL  = 12;
  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    TRG_SOFT   = 4'h0,
    TRG_TIMER  = 4'h1,
    TRG_GPIO   = 4'h2,
    TRG_ALWAYS = 4'h3
  } asq_trig_t;
  typedef struct packed {
    logic       start;
    logic [1:0] chan;
    logic       diff;
  } asq_conv_req_t;
  typedef struct packed {
    logic             done;
    logic [RES_W-1:0] data;
  } asq_conv_rsp_t;
endpackage

// >>> hdl/asq_sequencer.sv
// Four-sequence sample sequencer for a 10-bit, four-channel converter.
//
// Overview of operation
// - Each sample yields a 10-bit result from one of four input channels.
// - Samples of a sequence are taken in turn with no software action.
// - Per sequence: channel, trigger (software, timer, GPIO), interrupt and priority.
// - Four independent sequences of one to eight entries, each with a FIFO.
// - A triggered sequence captures its samples back to back until done.
// - Each entry sets channel, differential mode, interrupt and end marker.
// - Optional averaging of up to 64 conversions into one FIFO entry.
// - Conversion starts are paced to sustain 500 thousand samples per second.
// - FIFO depth and sample limit: eight, four, four and one.
// - FIFO entries read as 32-bit words with the result in bits 9:0.
// - Priorities 0 to 3, zero highest; software keeps them distinct.
// - Interrupt is raw status AND mask; writing one clears a status bit.
`timescale 1ns/10ps
`default_nettype none
module asq_sequencer (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  // Register port
  input  wire logic [7:0]             i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [31:0]            o_rdata,
  // Trigger pins from timers and GPIO
  input  wire logic                   i_trig_timer,
  input  wire logic                   i_trig_gpio,
  // Converter core
  output asq_pkg::asq_conv_req_t      o_conv,
  input  wire asq_pkg::asq_conv_rsp_t i_conv,
  // Interrupt
  output logic                        o_irq
);
  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT} asq_state_t;
  localparam int NS = asq_pkg::NSEQ;
  logic [NS-1:0]   enable_r, ris_r, im_r, ovf_r, unf_r, pend_r, ready;
  logic [15:0]     trigsel_r;
  logic [7:0]      prio_r;
  logic [2:0]      avg_r;
  logic [15:0]     mux_r   [NS];
  logic [31:0]     ctl_r   [NS];
  logic [9:0]      mem_r   [NS][8];
  logic [2:0]      wptr_r  [NS];
  logic [2:0]      rptr_r  [NS];
  logic [3:0]      cnt_r   [NS];
  logic [NS-1:0]   trig, pop, push_hit, ris_set, fifo_full, fifo_empty;
  logic [2:0]      sync_r  [2];
  logic [1:0]      pin_lvl_r, pin_rise;
  asq_state_t      state_r;
  logic [1:0]      cur_r, pick;
  logic [2:0]      idx_r;
  logic [6:0]      avg_cnt_r;
  logic [15:0]     acc_r, acc_sum;
  logic [7:0]      pace_r;
  logic            push, last, sel_seq, any_ready;
  logic [1:0]      ssel;
  logic [3:0]      nib;
  logic [3:0]      depth_cur;
  logic [31:0]     rd_mux;
  logic [9:0]      push_data;

  assign sel_seq = (i_addr[7:6] == asq_pkg::A_SEQ_SEL);
  assign ssel    = i_addr[5:4];

  // ---------------------------------------------------------------------------
  // Trigger pins: three flops, a change counts once the last two agree
  // ---------------------------------------------------------------------------
  // The first stage is read only by the second, keeping metastability contained.
  for (genvar p = 0; p < 2; p++) begin : g_pin
    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        sync_r[p]    <= 3'h0;
        pin_lvl_r[p] <= 1'b0;
      end else begin
        sync_r[p] <= {sync_r[p][1:0], (p == 0) ? i_trig_timer : i_trig_gpio};
        if (sync_r[p][1] == sync_r[p][2]) begin
          pin_lvl_r[p] <= sync_r[p][2];
        end
      end
    end
    assign pin_rise[p] = (sync_r[p][1] == sync_r[p][2]) && sync_r[p][2] && !pin_lvl_r[p];
  end

  // ---------------------------------------------------------------------------
  // Per-sequence trigger, pending flag and result FIFO
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < NS; g++) begin : g_seq
    logic [3:0] depth;
    logic [3:0] tsel;
    assign depth = asq_pkg::SEQ_DEPTH[4*g +: 4];
    assign tsel  = trigsel_r[4*g +: 4];
    // Trigger source chosen per sequence; the always source re-arms forever.
    always_comb begin
      unique case (tsel)
        asq_pkg::TRG_SOFT:   trig[g] = i_wr && (i_addr == asq_pkg::A_SWTRIG) && i_wdata[g];
        asq_pkg::TRG_TIMER:  trig[g] = pin_rise[0];
        asq_pkg::TRG_GPIO:   trig[g] = pin_rise[1];
        asq_pkg::TRG_ALWAYS: trig[g] = 1'b1;
        default:             trig[g] = 1'b0;
      endcase
    end
    assign fifo_full[g]  = (cnt_r[g] == depth);
    assign fifo_empty[g] = (cnt_r[g] == 4'h0);
    assign pop[g]        = i_rd && sel_seq && (ssel == 2'(g)) && (i_addr[3:2] == asq_pkg::S_FIFO);
    assign push_hit[g]   = push && (cur_r == 2'(g));
    assign ris_set[g]    = push_hit[g] && nib[asq_pkg::CTL_IE];
    // Pending is set by a trigger of an enabled sequence and cleared as it starts.
    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        pend_r[g] <= 1'b0;
      end else if (trig[g] && enable_r[g]) begin
        pend_r[g] <= 1'b1;
      end else if (state_r == ST_IDLE && any_ready && pick == 2'(g)) begin
        pend_r[g] <= 1'b0;
      end
    end
    // Circular buffer; a push when full is dropped and flagged as overflow.
    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        wptr_r[g] <= 3'h0;
        rptr_r[g] <= 3'h0;
        cnt_r[g]  <= 4'h0;
      end else begin
        if (push_hit[g] && !fifo_full[g]) begin
          mem_r[g][wptr_r[g]] <= push_data;
          wptr_r[g] <= (4'(wptr_r[g]) == depth - 4'h1) ? 3'h0 : wptr_r[g] + 3'h1;
        end
        if (pop[g] && !fifo_empty[g]) begin
          rptr_r[g] <= (4'(rptr_r[g]) == depth - 4'h1) ? 3'h0 : rptr_r[g] + 3'h1;
        end
        cnt_r[g] <= cnt_r[g] + 4'(push_hit[g] && !fifo_full[g]) - 4'(pop[g] && !fifo_empty[g]);
      end
    end
    fifo_bound_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      cnt_r[g] <= depth) else $error("FIFO count beyond its depth");
  end

  // ---------------------------------------------------------------------------
  // Arbitration: lowest priority value among ready sequences
  // ---------------------------------------------------------------------------
  assign ready     = pend_r & enable_r;
  assign any_ready = |ready;
  // Equal priorities fall back to the lower sequence number; software avoids this.
  always_comb begin
    logic [2:0] best;
    best = 3'h4;
    pick = 2'h0;
    for (int s = 0; s < NS; s++) begin
      if (ready[s] && {1'b0, prio_r[2*s +: 2]} < best) begin
        best = {1'b0, prio_r[2*s +: 2]};
        pick = 2'(s);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Sample engine
  // ---------------------------------------------------------------------------
  assign depth_cur = asq_pkg::SEQ_DEPTH[4*cur_r +: 4];
  assign nib       = ctl_r[cur_r][4*idx_r +: 4];
  assign last      = nib[asq_pkg::CTL_END] || (4'(idx_r) == depth_cur - 4'h1);
  assign acc_sum   = acc_r + 16'(i_conv.data);
  assign push      = (state_r == ST_WAIT) && i_conv.done && (avg_cnt_r + 7'h1 == 7'h1 << avg_r);
  assign push_data = 10'(acc_sum >> avg_r);

  // One sequence holds the converter from its first sample to its last.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r   <= ST_IDLE;
      cur_r     <= 2'h0;
      idx_r     <= 3'h0;
      acc_r     <= 16'h0;
      avg_cnt_r <= 7'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (any_ready) begin
            cur_r   <= pick;
            idx_r   <= 3'h0;
            state_r <= ST_START;
          end
        end
        ST_START: begin
          if (pace_r == 8'h0) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (i_conv.done) begin
            if (push) begin
              acc_r     <= 16'h0;
              avg_cnt_r <= 7'h0;
              if (last) begin
                state_r <= ST_IDLE;
              end else begin
                idx_r   <= idx_r + 3'h1;
                state_r <= ST_START;
              end
            end else begin
              acc_r     <= acc_sum;
              avg_cnt_r <= avg_cnt_r + 7'h1;
              state_r   <= ST_START;
            end
          end
        end
      endcase
    end
  end

  // Pacing counter spaces starts so the rate never exceeds one per sample period.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pace_r <= 8'h0;
    end else if (o_conv.start) begin
      pace_r <= asq_pkg::PACE_MAX;
    end else if (pace_r != 8'h0) begin
      pace_r <= pace_r - 8'h1;
    end
  end

  // Converter request comes straight from the current entry.
  assign o_conv.start = (state_r == ST_START) && (pace_r == 8'h0);
  assign o_conv.chan  = mux_r[cur_r][2*idx_r +: 2];
  assign o_conv.diff  = nib[asq_pkg::CTL_DIFF];

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  // Sequence settings may be rewritten while enabled; the engine reads them live.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      enable_r  <= '0;
      im_r      <= '0;
      trigsel_r <= 16'h0;
      prio_r    <= asq_pkg::PRIO_RST;
      avg_r     <= 3'h0;
      for (int s = 0; s < NS; s++) begin
        mux_r[s] <= 16'h0;
        ctl_r[s] <= 32'h0;
      end
    end else if (i_wr) begin
      unique case (i_addr)
        asq_pkg::A_ENABLE:  enable_r  <= i_wdata[NS-1:0];
        asq_pkg::A_MASK:    im_r      <= i_wdata[NS-1:0];
        asq_pkg::A_TRIGSEL: trigsel_r <= i_wdata[15:0];
        asq_pkg::A_PRIO:    prio_r    <= i_wdata[7:0];
        asq_pkg::A_AVG: begin
          avg_r <= (i_wdata[2:0] > asq_pkg::AVG_MAX) ? asq_pkg::AVG_MAX : i_wdata[2:0];
        end
        default: begin
          if (sel_seq && i_addr[3:2] == asq_pkg::S_MUX) begin
            mux_r[ssel] <= i_wdata[15:0];
          end
          if (sel_seq && i_addr[3:2] == asq_pkg::S_CTL) begin
            ctl_r[ssel] <= i_wdata;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Sticky status: hardware set wins over a write-one clear
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ris_r <= '0;
      ovf_r <= '0;
      unf_r <= '0;
    end else begin
      ris_r <= ris_set | (ris_r & ~((i_wr && i_addr == asq_pkg::A_STATCLR) ?
               i_wdata[NS-1:0] : 4'h0));
      ovf_r <= (push_hit & fifo_full) | (ovf_r & ~((i_wr && i_addr == asq_pkg::A_OVFL) ?
               i_wdata[NS-1:0] : 4'h0));
      unf_r <= (pop & fifo_empty) | (unf_r & ~((i_wr && i_addr == asq_pkg::A_UNFL) ?
               i_wdata[NS-1:0] : 4'h0));
    end
  end

  assign o_irq = |(ris_r & im_r);

  // ---------------------------------------------------------------------------
  // Read port: data stands only in the cycle after the strobe
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0;
    unique case (i_addr)
      asq_pkg::A_ENABLE:  rd_mux = 32'(enable_r);
      asq_pkg::A_RAWSTAT: rd_mux = 32'(ris_r);
      asq_pkg::A_MASK:    rd_mux = 32'(im_r);
      asq_pkg::A_STATCLR: rd_mux = 32'(ris_r & im_r);
      asq_pkg::A_TRIGSEL: rd_mux = 32'(trigsel_r);
      asq_pkg::A_PRIO:    rd_mux = 32'(prio_r);
      asq_pkg::A_AVG:     rd_mux = 32'(avg_r);
      asq_pkg::A_OVFL:    rd_mux = 32'(ovf_r);
      asq_pkg::A_UNFL:    rd_mux = 32'(unf_r);
      default: begin
        if (sel_seq) begin
          unique case (i_addr[3:2])
            asq_pkg::S_MUX:  rd_mux = 32'(mux_r[ssel]);
            asq_pkg::S_CTL:  rd_mux = ctl_r[ssel];
            asq_pkg::S_FIFO: rd_mux = fifo_empty[ssel] ? 32'h0 :
                                      32'(mem_r[ssel][rptr_r[ssel]]);
            asq_pkg::S_FSTAT: begin
              rd_mux = 32'(cnt_r[ssel]);
              rd_mux[asq_pkg::FST_EMPTY] = fifo_empty[ssel];
              rd_mux[asq_pkg::FST_FULL]  = fifo_full[ssel];
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0;
    end else begin
      o_rdata <= i_rd ? rd_mux : 32'h0;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  start_spacing_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_conv.start |=> (!o_conv.start) [*8]) else $error("Starts closer than pacing");
  pace_reload_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_conv.start |=> pace_r == asq_pkg::PACE_MAX) else $error("Pace not reloaded");
  seq_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r != ST_IDLE) && ($past(state_r) != ST_IDLE) |-> $stable(cur_r))
    else $error("Sequence changed mid-run");
  chan_sel_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_conv.start && !i_wr |=> $stable(o_conv.chan) && $stable(o_conv.diff))
    else $error("Request moved during conversion");
  irq_raise_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    push && nib[asq_pkg::CTL_IE] && im_r[cur_r] && !i_wr |=> o_irq)
    else $error("Interrupt missing after sample");
  clear_one_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_wr && i_addr == asq_pkg::A_STATCLR && i_wdata[0] && !ris_set[0] |=> !ris_r[0])
    else $error("Status bit not cleared");
  end_stop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    push && last |=> state_r == ST_IDLE) else $error("Sequence ran past its end");
  fifo_push_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    push && !fifo_full[cur_r] && !pop[cur_r] |=> cnt_r[$past(cur_r)] == $past(cnt_r[cur_r]) + 4'h1)
    else $error("Result not stored");
endmodule
`default_nettype wire

// >>> bench/asq_conv_model.sv
// Behavioural model of the converter core behind the sequencer.
`timescale 1ns/10ps
`default_nettype none
module asq_conv_model (
  // Clock, reset and answer delay
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire logic [15:0]            i_lat,
  // Converter link
  input  wire asq_pkg::asq_conv_req_t i_req,
  output asq_pkg::asq_conv_rsp_t      o_rsp,
  output logic                        o_bad
);
  int         cyc;
  int         last;
  int         left;
  logic       busy;
  logic [1:0] ch;
  logic       df;
  logic [6:0] k;
  logic [9:0] prev;

  // One conversion at a time; the result tags channel, mode and a running count.
  // Between answers the data lines show the inverse of the last result, so a
  // design that samples them outside done reads garbage, not a lucky value.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      busy  <= 1'b0;
      cyc   <= 0;
      last  <= -1000;
      k     <= 7'h00;
      prev  <= 10'h155;
      o_bad <= 1'b0;
      o_rsp <= '0;
    end else begin
      cyc        <= cyc + 1;
      o_rsp.done <= 1'b0;
      o_rsp.data <= ~prev;
      if (i_req.start) begin
        if (busy || (cyc - last) < asq_pkg::PACE_CYC) o_bad <= 1'b1;
        busy <= 1'b1;
        ch   <= i_req.chan;
        df   <= i_req.diff;
        left <= int'(i_lat);
        last <= cyc;
      end else if (busy) begin
        if (i_req.chan !== ch || i_req.diff !== df) o_bad <= 1'b1;
        if (left <= 1) begin
          busy       <= 1'b0;
          o_rsp.done <= 1'b1;
          o_rsp.data <= {ch, df, k};
          prev       <= {ch, df, k};
          k          <= k + 7'h01;
        end else begin
          left <= left - 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/adc_sample_sequencer_test.sv
// Self-checking bench of the four-sequence sample sequencer.
`timescale 1ns/10ps
`default_nettype none
module adc_sample_sequencer_test;
  logic                   i_clk, i_rst_n, i_wr, i_rd, i_trig_timer, i_trig_gpio;
  logic [7:0]             i_addr;
  logic [31:0]            i_wdata, o_rdata, d;
  logic                   o_irq, bad;
  logic [15:0]            lat;
  asq_pkg::asq_conv_req_t o_conv;
  asq_pkg::asq_conv_rsp_t i_conv;
  int                     n_errors, check_count, cnv_n, starts_seen;

  asq_sequencer u_asq_sequencer (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_trig_timer(i_trig_timer), .i_trig_gpio(i_trig_gpio), .o_conv(o_conv),
    .i_conv(i_conv), .o_irq(o_irq));
  asq_conv_model u_asq_conv_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_lat(lat),
    .i_req(o_conv), .o_rsp(i_conv), .o_bad(bad));

  // Clock at 125 MHz.
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // Count conversion starts so stray or missing conversions show up.
  always @(posedge i_clk) begin
    if (i_rst_n && o_conv.start === 1'b1) starts_seen <= starts_seen + 1;
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    v = o_rdata;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a, d);
    chk(nm, e, d);
  endtask
  function automatic logic [7:0] sa(input int n, input logic [1:0] w);
    return {asq_pkg::A_SEQ_SEL, 2'(n), w, 2'h0};
  endfunction
  // Expected next result of the converter model, in conversion order.
  function logic [31:0] ev(input logic [1:0] ch, input logic df);
    ev = {22'h0, ch, df, 7'(cnv_n)};
    cnv_n++;
  endfunction
  // Poll raw status under a bound; a long sequence takes about a thousand cycles.
  task automatic wait_raw(input logic [3:0] m);
    int i;
    for (i = 0; i < 3000; i++) begin
      rd(asq_pkg::A_RAWSTAT, d);
      if ((d[3:0] & m) === m) break;
    end
    if (i == 3000) chk("raw status", {28'h0, m}, d);
  endtask
  task automatic fin(input string nm);
    chk("converter link", 32'h0, {31'h0, bad});
    chk("start count", cnv_n, starts_seen);
    wr(asq_pkg::A_STATCLR, 32'hF);
    $display("test %s done", nm);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    rdc("enable", asq_pkg::A_ENABLE, 32'h0);
    rdc("mask", asq_pkg::A_MASK, 32'h0);
    rdc("trigger select", asq_pkg::A_TRIGSEL, 32'h0);
    rdc("priority", asq_pkg::A_PRIO, 32'hE4);
    rdc("averaging", asq_pkg::A_AVG, 32'h0);
    rdc("fifo0 status", sa(0, asq_pkg::S_FSTAT), 32'h100);
    wr(8'h30, 32'hFFFF_FFFF);
    rdc("unmapped", 8'h30, 32'h0);
    chk("irq", 32'h0, {31'h0, o_irq});
    fin("reset");
  endtask
  // Three entries out of eight, end marker on the third, mixed modes.
  task automatic t_seq_end;
    logic [31:0] e[3];
    wr(sa(0, asq_pkg::S_MUX), 32'h36);
    wr(sa(0, asq_pkg::S_CTL), 32'h601);
    wr(asq_pkg::A_MASK, 32'h1);
    wr(asq_pkg::A_ENABLE, 32'h1);
    e[0] = ev(2'h2, 1'b1);
    e[1] = ev(2'h1, 1'b0);
    e[2] = ev(2'h3, 1'b0);
    wr(asq_pkg::A_SWTRIG, 32'h1);
    wait_raw(4'h1);
    chk("irq set", 32'h1, {31'h0, o_irq});
    rdc("fifo0 count", sa(0, asq_pkg::S_FSTAT), 32'h3);
    for (int i = 0; i < 3; i++) rdc("fifo0 pop", sa(0, asq_pkg::S_FIFO), e[i]);
    rdc("fifo0 empty", sa(0, asq_pkg::S_FSTAT), 32'h100);
    rdc("masked status", asq_pkg::A_STATCLR, 32'h1);
    wr(asq_pkg::A_STATCLR, 32'h1);
    @(negedge i_clk);
    chk("irq clear", 32'h0, {31'h0, o_irq});
    fin("end marker");
  endtask
  // No end marker: sequence 1 must stop at four samples with a full FIFO.
  task automatic t_limit;
    logic [31:0] e[4];
    wr(asq_pkg::A_MASK, 32'h0);
    wr(sa(1, asq_pkg::S_MUX), 32'hE4);
    wr(sa(1, asq_pkg::S_CTL), 32'h4000);
    wr(asq_pkg::A_ENABLE, 32'h2);
    for (int i = 0; i < 4; i++) e[i] = ev(2'(i), 1'b0);
    wr(asq_pkg::A_SWTRIG, 32'h2);
    wait_raw(4'h2);
    repeat (300) @(posedge i_clk);
    chk("irq masked", 32'h0, {31'h0, o_irq});
    rdc("fifo1 full", sa(1, asq_pkg::S_FSTAT), 32'h1004);
    wr(asq_pkg::A_MASK, 32'h2);
    @(negedge i_clk);
    chk("irq unmasked", 32'h1, {31'h0, o_irq});
    for (int i = 0; i < 4; i++) rdc("fifo1 pop", sa(1, asq_pkg::S_FIFO), e[i]);
    fin("sample limit");
  endtask
  // Two sequences triggered together; sequence 2 outranks sequence 1.
  task automatic t_prio;
    logic [31:0] e[4];
    lat = 16'd400;
    wr(asq_pkg::A_MASK, 32'h0);
    wr(asq_pkg::A_PRIO, 32'hC6);
    wr(sa(2, asq_pkg::S_MUX), 32'h0F);
    wr(sa(2, asq_pkg::S_CTL), 32'h60);
    wr(sa(1, asq_pkg::S_MUX), 32'h04);
    wr(sa(1, asq_pkg::S_CTL), 32'h60);
    wr(asq_pkg::A_ENABLE, 32'h6);
    e[0] = ev(2'h3, 1'b0);
    e[1] = ev(2'h3, 1'b0);
    e[2] = ev(2'h0, 1'b0);
    e[3] = ev(2'h1, 1'b0);
    wr(asq_pkg::A_SWTRIG, 32'h6);
    wait_raw(4'h6);
    rdc("fifo2 pop", sa(2, asq_pkg::S_FIFO), e[0]);
    rdc("fifo2 pop", sa(2, asq_pkg::S_FIFO), e[1]);
    rdc("fifo1 pop", sa(1, asq_pkg::S_FIFO), e[2]);
    rdc("fifo1 pop", sa(1, asq_pkg::S_FIFO), e[3]);
    wr(asq_pkg::A_PRIO, 32'hE4);
    lat = 16'd3;
    fin("priority");
  endtask
  // Four conversions averaged into one entry, a second run dropped as overflow,
  // then a pop of the empty FIFO.
  task automatic t_avg;
    logic [31:0] s;
    s = 32'h0;
    wr(asq_pkg::A_AVG, 32'h2);
    wr(sa(3, asq_pkg::S_MUX), 32'h2);
    wr(sa(3, asq_pkg::S_CTL), 32'h4);
    wr(asq_pkg::A_ENABLE, 32'h8);
    repeat (4) s = s + ev(2'h2, 1'b0);
    wr(asq_pkg::A_SWTRIG, 32'h8);
    wait_raw(4'h8);
    repeat (4) void'(ev(2'h2, 1'b0));
    wr(asq_pkg::A_STATCLR, 32'h8);
    wr(asq_pkg::A_SWTRIG, 32'h8);
    wait_raw(4'h8);
    rdc("overflow", asq_pkg::A_OVFL, 32'h8);
    wr(asq_pkg::A_OVFL, 32'h8);
    rdc("overflow clear", asq_pkg::A_OVFL, 32'h0);
    rdc("averaged", sa(3, asq_pkg::S_FIFO), s >> 2);
    rdc("empty pop", sa(3, asq_pkg::S_FIFO), 32'h0);
    rdc("underflow", asq_pkg::A_UNFL, 32'h8);
    wr(asq_pkg::A_UNFL, 32'h8);
    rdc("underflow clear", asq_pkg::A_UNFL, 32'h0);
    wr(asq_pkg::A_AVG, 32'h0);
    fin("averaging");
  endtask
  // Timer pin starts sequence 2, GPIO pin starts sequence 0.
  task automatic t_pins;
    logic [31:0] e[3];
    wr(asq_pkg::A_TRIGSEL, 32'h102);
    wr(asq_pkg::A_ENABLE, 32'h5);
    e[0] = ev(2'h3, 1'b0);
    e[1] = ev(2'h3, 1'b0);
    @(posedge i_clk);
    i_trig_timer <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_trig_timer <= 1'b0;
    wait_raw(4'h4);
    for (int i = 0; i < 2; i++) rdc("timer pop", sa(2, asq_pkg::S_FIFO), e[i]);
    e[0] = ev(2'h2, 1'b1);
    e[1] = ev(2'h1, 1'b0);
    e[2] = ev(2'h3, 1'b0);
    @(posedge i_clk);
    i_trig_gpio <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_trig_gpio <= 1'b0;
    wait_raw(4'h1);
    for (int i = 0; i < 3; i++) rdc("gpio pop", sa(0, asq_pkg::S_FIFO), e[i]);
    wr(asq_pkg::A_ENABLE, 32'h0);
    fin("pin triggers");
  endtask

  // ---------------------------------------------------------------------------
  // Sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    {i_wr, i_rd, i_trig_timer, i_trig_gpio, i_rst_n} = 5'h0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    lat = 16'd3;
    {n_errors, check_count, cnv_n} = '0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_seq_end();
    t_limit();
    t_prio();
    t_avg();
    t_pins();
    close_out();
  end
  // The whole run needs about six thousand cycles.
  initial begin
    repeat (60000) @(posedge i_clk);
    n_errors++;
    $display("[ERR] run time expected finish seen hang");
    close_out();
  end
endmodule
`default_nettype wire
